// *** tpc16_timer_pwm_capture16.sv ***
// Cascaded 16-bit timer with capture, and the 10-bit double-buffered PWM on timer 1.
`timescale 1ns/1ps
// What this block does
// - 16-bit capture cascades both timers into one count.
// - Timer 0 select picks prescaler or event pin.
// - Pin select routes PWM to the output pin.
// - PWM and timer share one counter.
// - Period is high bits 3:2 plus low byte.
// - Duty is high bits 1:0 plus low byte.
// - Period and duty count source clock ticks.
// - Duty master moves to slave at period match.
// - Duty changes take effect next period only.
// - Polarity picks the level of duty portion.
// - Duty equal period holds the duty level.
// - Zero duty holds the opposite level.
// - Period change keeps absolute duty time.
// - Capture edge stores count, clears and restarts.
// - Capture mode reads capture, writes compare.
// - Edge select chooses capture edge; raises interrupt.
// - Count matches compare, clears, raises timer 0.
module tpc16_timer_pwm_capture16
  import tpc16_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] t0ClockSelect,
  input wire logic [1:0] t1ClockSelect,
  input wire logic cascadeSelect,
  input wire logic captureEnable,
  input wire logic pwmEnable,
  input wire logic outputPolarity,
  input wire logic pwmPinSelect,
  input wire logic [7:0] pwmPeriodLow,
  input wire logic [7:0] pwmDutyLow,
  input wire logic [3:0] pwmHighBits,
  input wire logic dutyWrite,
  input wire logic [CNT_W-1:0] compareData,
  input wire logic [1:0] edgeSelect,
  input wire logic captureEdgeInput,
  input wire logic eventCountPin,
  output logic pwmPin,
  output logic pwmPinEnable,
  output logic timer0Irq,
  output logic captureIrq,
  output logic [CNT_W-1:0] captureData,
  output logic [CNT_W-1:0] timerReadData
);

  // ****************************************
  // Declarations
  // ****************************************
  tpc16_state_s st_r;
  tpc16_state_s st_nxt;
  logic t0Tick;
  logic t1Tick;
  logic captureEdge;
  logic eventEdge;
  logic cascadeMode;
  logic pwmMode;
  logic cascadeTick;
  logic [PWM_W-1:0] periodVal;
  logic [PWM_W-1:0] dutyVal;
  logic [PWM_W-1:0] periodLast;
  logic [PWM_W-1:0] pwmCount;
  logic pwmWrap;
  logic captureHit;
  logic matchHit;

  // ****************************************
  // Clock sources and pin inputs
  // ****************************************
  tpc16_prescaler u_prescaler (
    .clk(clk),
    .reset(reset),
    .t0ClockSelect(t0ClockSelect),
    .t1ClockSelect(t1ClockSelect),
    .t0Tick(t0Tick),
    .t1Tick(t1Tick)
  );

  // The capture pin edge follows the edge selection setting.
  tpc16_edge_sync u_capture_sync (
    .clk(clk),
    .reset(reset),
    .pinIn(captureEdgeInput),
    .edgeMode(edgeSelect),
    .edgePulse(captureEdge)
  );

  // The event pin counts on rising transitions.
  tpc16_edge_sync u_event_sync (
    .clk(clk),
    .reset(reset),
    .pinIn(eventCountPin),
    .edgeMode(EDGE_RISE),
    .edgePulse(eventEdge)
  );

  // ****************************************
  // Mode decode and operand assembly
  // ****************************************
  // Cascade needs both timer 1 clock bits and the cascade bit set; PWM yields to it.
  assign cascadeMode = cascadeSelect && (t1ClockSelect == T1_SEL_CASCADE);
  assign pwmMode = pwmEnable && !cascadeMode;
  assign cascadeTick = (t0ClockSelect == T0_SEL_EVENT) ? eventEdge : t0Tick;
  assign periodVal = {pwmHighBits[3:2], pwmPeriodLow};
  assign dutyVal = {pwmHighBits[1:0], pwmDutyLow};
  assign periodLast = periodVal - 10'h001;
  assign pwmCount = st_r.count[PWM_W-1:0];
  assign pwmWrap = pwmMode && t1Tick && (periodVal != 10'h000) && (pwmCount >= periodLast);
  assign captureHit = cascadeMode && captureEnable && captureEdge;
  assign matchHit = cascadeMode && !captureHit && cascadeTick && (st_r.count == compareData);

  // ****************************************
  // Next-state logic
  // ****************************************
  // One record holds the shared count, capture latch, duty stages and output flops.
  always_comb begin
    st_nxt = st_r;
    st_nxt.timer0Irq = 1'b0;
    st_nxt.captureIrq = 1'b0;
    if (dutyWrite) begin
      st_nxt.dutyMaster = dutyVal;
    end
    if (cascadeMode) begin
      if (captureHit) begin
        st_nxt.captureData = st_r.count;
        st_nxt.count = COUNT_RST;
        st_nxt.captureIrq = 1'b1;
      end else if (matchHit) begin
        st_nxt.count = COUNT_RST;
        st_nxt.timer0Irq = 1'b1;
      end else if (cascadeTick) begin
        st_nxt.count = st_r.count + 16'h0001;
      end
    end else if (pwmMode) begin
      if (pwmWrap) begin
        st_nxt.count = COUNT_RST;
        st_nxt.dutySlave = st_nxt.dutyMaster;
      end else if (t1Tick && (periodVal != 10'h000)) begin
        st_nxt.count = st_r.count + 16'h0001;
      end
    end else begin
      st_nxt.count = COUNT_RST;
    end
    // Duty portion first at the polarity level, then the other level for the rest.
    if (pwmMode) begin
      st_nxt.pwmOut = (st_nxt.count[PWM_W-1:0] < st_nxt.dutySlave) ? outputPolarity
                                                                   : !outputPolarity;
    end else begin
      st_nxt.pwmOut = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r.count <= COUNT_RST;
      st_r.captureData <= COUNT_RST;
      st_r.dutyMaster <= DUTY_RST;
      st_r.dutySlave <= DUTY_RST;
      st_r.pwmOut <= 1'b0;
      st_r.timer0Irq <= 1'b0;
      st_r.captureIrq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Capture mode reads the latch; otherwise software sees the live count.
  assign timerReadData = (cascadeMode && captureEnable) ? st_r.captureData : st_r.count;
  assign captureData = st_r.captureData;
  assign pwmPin = st_r.pwmOut;
  assign pwmPinEnable = pwmPinSelect;
  assign timer0Irq = st_r.timer0Irq;
  assign captureIrq = st_r.captureIrq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence sPwmSteady;
    pwmMode ##1 pwmMode;
  endsequence

  sequence sCapture;
    captureHit;
  endsequence

  a_capture_copy: assert property (sCapture |=> (captureData == $past(st_r.count)) && (st_r.count == 16'h0000))
    else $error("Capture did not store the count and clear it.");

  a_capture_irq: assert property (sCapture |=> captureIrq ##1 !captureIrq)
    else $error("Capture interrupt was not a single pulse.");

  a_match_clear: assert property (matchHit |=> timer0Irq && (st_r.count == 16'h0000))
    else $error("Compare match did not clear the count and raise timer 0.");

  a_event_source: assert property (cascadeMode && (t0ClockSelect == T0_SEL_EVENT) && !eventEdge && !captureHit
                                   |=> $stable(st_r.count))
    else $error("Cascaded count moved with no event edge.");

  a_read_mux: assert property (cascadeMode && captureEnable |-> timerReadData == captureData)
    else $error("Capture mode read did not return the capture latch.");

  a_duty_hold: assert property (!pwmWrap && !reset |=> $stable(st_r.dutySlave))
    else $error("Duty slave changed outside a period match.");

  a_duty_load: assert property (pwmWrap |=> st_r.dutySlave == $past(st_nxt.dutyMaster))
    else $error("Duty slave did not load the master at period match.");

  a_period_wrap: assert property (pwmWrap |=> st_r.count == 16'h0000 ##1 st_r.count <= 16'h0001)
    else $error("PWM counter did not restart at period match.");

  a_full_duty: assert property (sPwmSteady ##0 (st_r.dutySlave == periodVal) && (periodVal != 10'h000)
                                |-> pwmPin == $past(outputPolarity))
    else $error("Full duty output was not held at the polarity level.");

  a_zero_duty: assert property (sPwmSteady ##0 (st_r.dutySlave == 10'h000) |-> pwmPin == !$past(outputPolarity))
    else $error("Zero duty output was not held at the opposite level.");

  a_pwm_exclusive: assert property (cascadeMode |-> !pwmMode)
    else $error("PWM ran while the counter was cascaded.");

  // ****************************************
  // Assertions on counting, latching and interrupts
  // ****************************************
  sequence sWrap;
    pwmWrap;
  endsequence

  // A PWM tick below the period advances the shared counter by one.
  a_pwm_advance: assert property (pwmMode && t1Tick && !pwmWrap && (periodVal != 10'h000)
                                  |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("PWM counter did not advance on a source tick.");

  // Between source ticks the PWM counter must not move.
  a_pwm_hold: assert property (pwmMode && !t1Tick |=> $stable(st_r.count))
    else $error("PWM counter moved without a source tick.");

  // A zero period parks the counter instead of wrapping every tick.
  a_period_zero: assert property (pwmMode && (periodVal == 10'h000) |=> $stable(st_r.count))
    else $error("PWM counter moved with a zero period.");

  // Each cascaded tick that neither captures nor matches adds one to the 16-bit count.
  a_cascade_step: assert property (cascadeMode && cascadeTick && !captureHit && !matchHit
                                   |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("Cascaded count did not advance on a tick.");

  // With the prescaler selected, only a prescaler tick or a capture may move the cascaded count.
  a_prescale_source: assert property (cascadeMode && (t0ClockSelect != T0_SEL_EVENT) && !t0Tick && !captureHit
                                      |=> $stable(st_r.count))
    else $error("Cascaded count moved with no prescaler tick.");

  // The capture latch only changes on a capture.
  a_latch_hold: assert property (!captureHit |=> $stable(captureData))
    else $error("Capture latch changed without a capture.");

  // A timer 0 pulse always follows a compare match.
  a_match_source: assert property (timer0Irq |-> $past(matchHit))
    else $error("Timer 0 pulse without a compare match.");

  // A capture pulse always follows a capture.
  a_capture_source: assert property (captureIrq |-> $past(captureHit))
    else $error("Capture pulse without a capture.");

  // Outside the cascade neither interrupt pulse may appear.
  a_irq_quiet: assert property (!cascadeMode |=> !timer0Irq && !captureIrq)
    else $error("Interrupt pulse outside the cascaded mode.");

  // The output rests low whenever PWM is not running.
  a_pwm_idle: assert property (!pwmMode |=> !pwmPin)
    else $error("Output moved while PWM was not running.");

  // A duty write lands in the master stage on the next edge.
  a_master_load: assert property (dutyWrite |=> st_r.dutyMaster == $past(dutyVal))
    else $error("Duty master did not take the written value.");

  // Without a write the master stage keeps its value.
  a_master_hold: assert property (!dutyWrite |=> $stable(st_r.dutyMaster))
    else $error("Duty master changed without a write.");

  // Leaving both modes clears the shared counter.
  a_mode_clear: assert property (!cascadeMode && !pwmMode |=> st_r.count == 16'h0000)
    else $error("Counter was not cleared with both modes off.");

  // Each period opens at the duty level unless the duty is zero.
  a_start_level: assert property (sWrap |=> pwmPin == ((st_r.dutySlave != 10'h000) ? $past(outputPolarity)
                                                                                    : !$past(outputPolarity)))
    else $error("Period did not open at the expected level.");

  // The output shows the duty level below the duty value and the other level at or above it.
  a_duty_level: assert property (sPwmSteady |-> pwmPin == ((pwmCount < st_r.dutySlave) ? $past(outputPolarity)
                                                                                       : !$past(outputPolarity)))
    else $error("Output level did not follow the duty value.");

endmodule : tpc16_timer_pwm_capture16

// *** tpc16_pkg.sv ***
// Shared constants and types for the cascaded timer, capture and PWM block.
package tpc16_pkg;

  // ****************************************
  // Widths and mode encodings
  // ****************************************
  localparam int PWM_W = 10;
  localparam int CNT_W = 16;
  localparam int PRE_W = 11;
  localparam logic [2:0] T0_SEL_EVENT = 3'h7;
  localparam logic [1:0] T1_SEL_CASCADE = 2'h3;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ****************************************
  // Prescaler divide ratios as shift amounts
  // ****************************************
  // Timer 0 ratios 2, 4, 8, 32, 128, 512, 2048; the last code selects the event pin.
  localparam logic [3:0] T0_DIV_SHIFT [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'h0};
  // Timer 1 ratios 1, 2, 8; the last code selects the cascade.
  localparam logic [3:0] T1_DIV_SHIFT [4] = '{4'h0, 4'h1, 4'h3, 4'h0};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [PWM_W-1:0] DUTY_RST = 10'h000;
  localparam logic [PRE_W-1:0] PRE_RST = 11'h000;

  // ****************************************
  // State records
  // ****************************************
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] captureData;
    logic [PWM_W-1:0] dutyMaster;
    logic [PWM_W-1:0] dutySlave;
    logic pwmOut;
    logic timer0Irq;
    logic captureIrq;
  } tpc16_state_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic edgeSeen;
  } tpc16_edge_s;

endpackage : tpc16_pkg

// *** tpc16_prescaler.sv ***
// Free-running prescaler that yields the timer 0 and timer 1 source ticks.
`timescale 1ns/1ps
module tpc16_prescaler
  import tpc16_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] t0ClockSelect,
  input wire logic [1:0] t1ClockSelect,
  output logic t0Tick,
  output logic t1Tick
);

  logic [PRE_W-1:0] preCount_r;
  logic [PRE_W-1:0] preCount_nxt;
  logic [PRE_W-1:0] mask0;
  logic [PRE_W-1:0] mask1;

  // ****************************************
  // Divider
  // ****************************************
  // A tick fires once every 2^shift clocks, when the low shift bits are all ones.
  always_comb begin
    preCount_nxt = preCount_r + 11'h001;
    mask0 = PRE_W'((12'h001 << T0_DIV_SHIFT[t0ClockSelect]) - 12'h001);
    mask1 = PRE_W'((12'h001 << T1_DIV_SHIFT[t1ClockSelect]) - 12'h001);
    t0Tick = ((preCount_r & mask0) == mask0);
    t1Tick = ((preCount_r & mask1) == mask1);
  end

  // The divider runs freely so both timers share one phase reference.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      preCount_r <= PRE_RST;
    end else begin
      preCount_r <= preCount_nxt;
    end
  end

endmodule : tpc16_prescaler

// *** tpc16_edge_sync.sv ***
// Two-stage pin synchroniser with a selectable edge detector.
`timescale 1ns/1ps
module tpc16_edge_sync
  import tpc16_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pinIn,
  input wire logic [1:0] edgeMode,
  output logic edgePulse
);

  tpc16_edge_s st_r;
  tpc16_edge_s st_nxt;

  // ****************************************
  // Synchroniser and edge detect
  // ****************************************
  // Only the second stage feeds the detector, so metastability stays in the first stage.
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pinIn;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    case (edgeMode)
      EDGE_FALL: st_nxt.edgeSeen = st_r.prev & ~st_r.sync2;
      EDGE_RISE: st_nxt.edgeSeen = ~st_r.prev & st_r.sync2;
      EDGE_BOTH: st_nxt.edgeSeen = st_r.prev ^ st_r.sync2;
      default: st_nxt.edgeSeen = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edgePulse = st_r.edgeSeen;

endmodule : tpc16_edge_sync

// *** tpc16_pin_partner.sv ***
// Model of the outside world that drives the capture line and the event pin.
`timescale 1ns/1ps
module tpc16_pin_partner (
  input wire logic clk,
  output logic capturePin,
  output logic eventPin
);
  // Both lines start idle: the capture line rests high, the event line low.
  initial begin
    capturePin = 1'b1;
    eventPin = 1'b0;
  end

  // Holds the present level for n edges, so every transition stays wide enough for the synchroniser.
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : hold

  // Gives one falling and one rising edge on the capture line, then rests until the answer has landed.
  task automatic capture_pulse();
    capturePin = 1'b0;
    hold(6);
    capturePin = 1'b1;
    hold(8);
  endtask : capture_pulse

  // Sends n rising edges on the event pin, each level held for three edges.
  task automatic event_pulses(input int n);
    repeat (n) begin
      eventPin = 1'b1;
      hold(3);
      eventPin = 1'b0;
      hold(3);
    end
  endtask : event_pulses
endmodule : tpc16_pin_partner

// *** tpc16_timer_pwm_capture16_tb.sv ***
// Self-checking bench for the cascaded timer, capture and 10-bit PWM block.
`timescale 1ns/1ps
module tpc16_timer_pwm_capture16_tb;
  import tpc16_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] t0Sel = 3'h0;
  logic [1:0] t1Sel = 2'h0;
  logic casc = 1'b0, capEn = 1'b0, pwmEn = 1'b0, output_polarity = 1'b0, pinSel = 1'b0, dutyWr = 1'b0;
  logic [7:0] perLow = 8'h00, dutyLow = 8'h00;
  logic [3:0] highBits = 4'h0;
  logic [15:0] cmp = 16'hFFFF;
  logic [1:0] edgeSel = EDGE_NONE;
  logic capPin, evtPin, pwmPin, pinEn, t0Irq, capIrq;
  logic [15:0] capData, rdData;
  int errors = 0, n_compared = 0, capIrqs = 0, t0Irqs = 0;
  int p, d, k, r, n0, e, prev, c;
  int unsigned seedDummy;

  tpc16_pin_partner i_tpc16_pin_partner (.clk(clk), .capturePin(capPin), .eventPin(evtPin));
  tpc16_timer_pwm_capture16 i_tpc16_timer_pwm_capture16 (.clk(clk), .reset(reset), .t0ClockSelect(t0Sel),
    .t1ClockSelect(t1Sel), .cascadeSelect(casc), .captureEnable(capEn), .pwmEnable(pwmEn),
    .outputPolarity(output_polarity), .pwmPinSelect(pinSel), .pwmPeriodLow(perLow), .pwmDutyLow(dutyLow),
    .pwmHighBits(highBits), .dutyWrite(dutyWr), .compareData(cmp), .edgeSelect(edgeSel),
    .captureEdgeInput(capPin), .eventCountPin(evtPin), .pwmPin(pwmPin), .pwmPinEnable(pinEn),
    .timer0Irq(t0Irq), .captureIrq(capIrq), .captureData(capData), .timerReadData(rdData));

  // The clock toggles every half period of 50 ns, and interrupt pulses are tallied at each rising edge.
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (capIrq === 1'b1) capIrqs++;
    if (t0Irq === 1'b1) t0Irqs++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Moves to just after the n-th next rising edge, where inputs change and outputs are settled.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // Waits for the output to reach a level, giving up after a bounded count.
  task automatic wait_pin(input logic lvl);
    int i;
    for (i = 0; i < 4000 && pwmPin !== lvl; i++) step(1);
    if (i == 4000) begin
      errors++;
      $display("Wait for output level timed out");
      end_sim();
    end
  endtask : wait_pin

  task automatic set_period(input logic [9:0] v);
    perLow = v[7:0];
    highBits[3:2] = v[9:8];
  endtask : set_period

  // Writes the duty master; the caller lowers the strobe after the next step.
  task automatic set_duty(input logic [9:0] v);
    dutyLow = v[7:0];
    highBits[1:0] = v[9:8];
    dutyWr = 1'b1;
  endtask : set_duty

  // Measures one whole run at a level, optionally writing a new duty in its first cycle.
  task automatic run_len(input logic lvl, input logic wr, input logic [9:0] nd, output int n);
    wait_pin(!lvl);
    wait_pin(lvl);
    n = 0;
    if (wr) set_duty(nd);
    while (pwmPin === lvl && n < 4000) begin
      n++;
      step(1);
      dutyWr = 1'b0;
    end
    if (n == 4000) begin
      errors++;
      $display("Run length measurement timed out");
      end_sim();
    end
  endtask : run_len

  // Expected cycles at the duty level in one period, with r clock cycles to each source tick.
  function automatic int exp_on(input int per, input int dut, input int rat);
    return rat * ((dut >= per) ? per : dut);
  endfunction : exp_on

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seedDummy = $urandom(32'hd98b);
    step(3);
    check({12'h000, pinEn, pwmPin, t0Irq, capIrq}, 16'h0000);
    check(capData, 16'h0000);
    check(rdData, 16'h0000);
    reset = 1'b0;
    pwmEn = 1'b1;
    pinSel = 1'b1;
    step(1);
    check({15'h0000, pinEn}, 16'h0001);
    // Duty share over a period for both polarities, both edge cases and three source clocks.
    for (int i = 0; i < 6; i++) begin
      r = (i < 4) ? 1 : (i == 4) ? 2 : 8;
      t1Sel = (i < 4) ? 2'h0 : (i == 4) ? 2'h1 : 2'h2;
      output_polarity = i[0];
      p = 16 + $urandom % 700;
      d = (i == 2) ? 0 : (i == 3) ? p : 1 + $urandom % (p - 1);
      set_period(10'(p));
      set_duty(10'(d));
      step(1);
      dutyWr = 1'b0;
      step(2 * p * r + 20);
      k = 0;
      repeat (p * r) begin
        if (pwmPin === output_polarity) k++;
        step(1);
      end
      check(16'(k), 16'(exp_on(p, d, r)));
    end
    $display("Test duty share done");
    // A duty written in mid-period waits for the wrap; a period change keeps the duty time.
    t1Sel = 2'h0;
    output_polarity = 1'b1;
    p = 300 + $urandom % 200;
    d = 50 + $urandom % 100;
    c = 150 + $urandom % 100;
    set_period(10'(p));
    set_duty(10'(d));
    step(1);
    dutyWr = 1'b0;
    step(2 * p + 10);
    run_len(1'b1, 1'b1, 10'(c), k);
    check(16'(k), 16'(d));
    run_len(1'b1, 1'b0, 10'h000, k);
    check(16'(k), 16'(c));
    set_period(10'(p + 100));
    run_len(1'b1, 1'b0, 10'h000, k);
    check(16'(k), 16'(c));
    run_len(1'b0, 1'b0, 10'h000, k);
    check(16'(k), 16'(p + 100 - c));
    $display("Test double buffer done");
    // Cascaded capture counting event edges, for every edge selection.
    // PWM stays requested, so the cascade itself must hold it off.
    casc = 1'b1;
    t1Sel = T1_SEL_CASCADE;
    t0Sel = T0_SEL_EVENT;
    capEn = 1'b1;
    step(5);
    check({15'h0000, pwmPin}, 16'h0000);
    prev = 0;
    for (int m = 1; m < 5; m++) begin
      edgeSel = m[1:0];
      step(2);
      i_tpc16_pin_partner.capture_pulse();
      n0 = capIrqs;
      k = 1 + $urandom % 40;
      i_tpc16_pin_partner.event_pulses(k);
      i_tpc16_pin_partner.capture_pulse();
      check(16'(capIrqs - n0), (m == 3) ? 16'h0002 : (m == 4) ? 16'h0000 : 16'h0001);
      e = (m == 4) ? prev : (m == 3) ? 0 : k;
      check(capData, 16'(e));
      check(rdData, 16'(e));
      prev = e;
    end
    // Capture on the internal prescaled clock, two falls 214 cycles apart giving 107 ticks.
    t0Sel = 3'h0;
    edgeSel = EDGE_FALL;
    i_tpc16_pin_partner.capture_pulse();
    step(200);
    i_tpc16_pin_partner.capture_pulse();
    check({15'h0000, capData <= 16'h006B && capData >= 16'h006A}, 16'h0001);
    $display("Test capture done");
    // Compare match above eight bits on event edges raises the timer 0 pulse and clears.
    capEn = 1'b0;
    pwmEn = 1'b0;
    t1Sel = 2'h0;
    t0Sel = T0_SEL_EVENT;
    step(3);
    // Without both timer 1 clock bits set the cascade stays off and ignores events.
    i_tpc16_pin_partner.event_pulses(2);
    check(rdData, 16'h0000);
    c = 16'h0100 + $urandom % 16;
    cmp = 16'(c);
    t1Sel = T1_SEL_CASCADE;
    step(3);
    n0 = t0Irqs;
    i_tpc16_pin_partner.event_pulses(c);
    check(rdData, 16'(c));
    check(16'(t0Irqs - n0), 16'h0000);
    i_tpc16_pin_partner.event_pulses(1);
    check(16'(t0Irqs - n0), 16'h0001);
    check(rdData, 16'h0000);
    $display("Test compare match done");
    end_sim();
  end
endmodule : tpc16_timer_pwm_capture16_tb
